/* File: incr_skip_or_defines.svh */
`ifndef INCR_SKIP_OR_DEFINES_SVH
`define INCR_SKIP_OR_DEFINES_SVH

// Opcode patterns on the 14-bit program word.
`define OP_INCR_SKIP_HI 6'h0f
`define OP_OR_FILE_HI 6'h04
`define OP_OR_LIT_HI 6'h38
`define OP_HI_MSB 13
`define OP_HI_LSB 8
`define DEST_BIT 7
`define FADDR_MSB 6
`define LIT_MSB 7
`define W_RESET 8'h00
`define Z_RESET 1'b0
`define QPHASE_RESET 2'h0

`endif

/* File: incr_skip_or_pkg.sv */
package incr_skip_or_pkg;

    typedef enum logic [1:0] {
        OPK_NONE,
        OPK_INCR_SKIP,
        OPK_OR_LIT,
        OPK_OR_FILE
    } op_kind_t;

    typedef struct packed {
        op_kind_t kind;
        logic dest_file;
        logic [6:0] faddr;
        logic [7:0] literal;
    } decoded_t;

    typedef struct packed {
        logic wr_en;
        logic [6:0] addr;
        logic [7:0] data;
    } file_write_t;

endpackage

/* File: op_decoder.sv */
`timescale 1ns/1ps
`include "incr_skip_or_defines.svh"

module op_decoder (
    input wire logic [13:0] word_i,
    output incr_skip_or_pkg::decoded_t dec_o
);

    always_comb begin
        dec_o.kind = incr_skip_or_pkg::OPK_NONE;
        dec_o.dest_file = word_i[`DEST_BIT];
        dec_o.faddr = word_i[`FADDR_MSB:0];
        dec_o.literal = word_i[`LIT_MSB:0];
        case (word_i[`OP_HI_MSB:`OP_HI_LSB])
            `OP_INCR_SKIP_HI: dec_o.kind = incr_skip_or_pkg::OPK_INCR_SKIP;
            `OP_OR_LIT_HI: dec_o.kind = incr_skip_or_pkg::OPK_OR_LIT;
            `OP_OR_FILE_HI: dec_o.kind = incr_skip_or_pkg::OPK_OR_FILE;
            default: dec_o.kind = incr_skip_or_pkg::OPK_NONE;
        endcase
    end

endmodule // op_decoder

/* File: incr_skip_and_or_ops.sv */
// Overview of operation
// - Word 00 1111 dfff ffff is decoded and adds one to the addressed file register.
// - The incremented value goes to the working register when d is 0, else to the file.
// - A zero increment result turns the next instruction into a no-operation cycle.
// - A nonzero increment result lets the next instruction run normally in one cycle.
// - The skip cycle writes neither the working register, the zero flag nor any file register.
// - Word 11 1000 kkkk kkkk ORs the working register with the literal into itself.
// - The literal OR completes in one cycle, writing the working register in the fourth quarter.
// - Word 00 0100 dfff ffff ORs working and file registers into the chosen destination.
`timescale 1ns/1ps
`include "incr_skip_or_defines.svh"

module incr_skip_and_or_ops (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    output logic [1:0] qphase_o,
    output logic [6:0] file_raddr_o,
    output incr_skip_or_pkg::file_write_t file_wr_o,
    output logic [7:0] working_register_o,
    output logic zero_flag_o,
    output logic skip_cycle_o,
    output logic cycle_end_o
);

    // One instruction cycle is four clocks; qphase 0..3 stands for Q1..Q4.
    // The fetch path holds instr_i stable for the whole cycle.
    logic [1:0] qphase_reg;
    logic skip_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic [7:0] w_reg;
    logic z_reg;
    incr_skip_or_pkg::decoded_t dec_reg;
    incr_skip_or_pkg::decoded_t dec_now;
    logic result_zero_reg;
    logic fw_wr_en_reg;
    logic [6:0] fw_addr_reg;
    logic [7:0] fw_data_reg;
    logic [6:0] raddr_reg;
    logic cycle_end_reg;

    op_decoder u_dec (
        .word_i(instr_i),
        .dec_o(dec_now)
    );

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qphase_reg <= `QPHASE_RESET;
        end else begin
            qphase_reg <= qphase_reg + 2'h1;
        end
    end

    // Q1: decode; a skip cycle latches an empty operation so Q2 to Q4 do nothing.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_reg <= '0;
        end else if (qphase_reg == 2'h0) begin
            if (skip_reg) begin
                dec_reg <= '0;
            end else begin
                dec_reg <= dec_now;
            end
        end
    end

    // The read address is left alone in a skipped cycle so the file read port stays quiet.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raddr_reg <= 7'h00;
        end else if (qphase_reg == 2'h0 && !skip_reg) begin
            raddr_reg <= dec_now.faddr;
        end
    end

    // Q2: read the file register or the literal.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operand_reg <= 8'h00;
        end else if (qphase_reg == 2'h1) begin
            if (dec_reg.kind == incr_skip_or_pkg::OPK_OR_LIT) begin
                operand_reg <= dec_reg.literal;
            end else begin
                operand_reg <= file_rdata_i;
            end
        end
    end

    // Q3: process.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg <= 8'h00;
        end else if (qphase_reg == 2'h2) begin
            case (dec_reg.kind)
                incr_skip_or_pkg::OPK_INCR_SKIP: result_reg <= operand_reg + 8'h01;
                incr_skip_or_pkg::OPK_OR_LIT: result_reg <= w_reg | operand_reg;
                incr_skip_or_pkg::OPK_OR_FILE: result_reg <= w_reg | operand_reg;
                default: result_reg <= 8'h00;
            endcase
        end
    end

    // Q4: write to the destination, update the zero flag and arm the skip.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_reg <= `W_RESET;
        end else if (qphase_reg == 2'h3) begin
            case (dec_reg.kind)
                incr_skip_or_pkg::OPK_INCR_SKIP: begin
                    if (!dec_reg.dest_file) begin
                        w_reg <= result_reg;
                    end
                end
                incr_skip_or_pkg::OPK_OR_LIT: w_reg <= result_reg;
                incr_skip_or_pkg::OPK_OR_FILE: begin
                    if (!dec_reg.dest_file) begin
                        w_reg <= result_reg;
                    end
                end
                default: w_reg <= w_reg;
            endcase
        end
    end

    // Zero detect is taken in Q3 next to the adder, so Q4 only has to pick a destination.
    // This keeps the skip decision off the carry chain at the cost of one flip-flop.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_zero_reg <= 1'b0;
        end else if (qphase_reg == 2'h2) begin
            case (dec_reg.kind)
                incr_skip_or_pkg::OPK_INCR_SKIP: result_zero_reg <= (operand_reg == 8'hff);
                incr_skip_or_pkg::OPK_OR_LIT,
                incr_skip_or_pkg::OPK_OR_FILE: begin
                    result_zero_reg <= ((w_reg | operand_reg) == 8'h00);
                end
                default: result_zero_reg <= 1'b0;
            endcase
        end
    end

    // The increment leaves the zero flag untouched, unlike the plain increment.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            z_reg <= `Z_RESET;
        end else if (qphase_reg == 2'h3) begin
            if (dec_reg.kind == incr_skip_or_pkg::OPK_OR_LIT
                || dec_reg.kind == incr_skip_or_pkg::OPK_OR_FILE) begin
                z_reg <= result_zero_reg;
            end
        end
    end

    // The write strobe is a one-clock pulse in Q4 so the register file sees one edge.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fw_wr_en_reg <= 1'b0;
        end else begin
            fw_wr_en_reg <= (qphase_reg == 2'h2) && dec_reg.dest_file
                && (dec_reg.kind == incr_skip_or_pkg::OPK_INCR_SKIP
                    || dec_reg.kind == incr_skip_or_pkg::OPK_OR_FILE);
        end
    end

    // Address and data load in every Q3; only the strobe says whether they matter.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fw_addr_reg <= 7'h00;
        end else if (qphase_reg == 2'h2) begin
            fw_addr_reg <= dec_reg.faddr;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fw_data_reg <= 8'h00;
        end else if (qphase_reg == 2'h2) begin
            if (dec_reg.kind == incr_skip_or_pkg::OPK_INCR_SKIP) begin
                fw_data_reg <= operand_reg + 8'h01;
            end else begin
                fw_data_reg <= w_reg | operand_reg;
            end
        end
    end

    // The skip flag is set at the end of the increment cycle and covers the whole next cycle.
    // A skipped cycle decodes as empty, so it clears the flag again at its own end.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_reg <= 1'b0;
        end else if (qphase_reg == 2'h3) begin
            skip_reg <= (dec_reg.kind == incr_skip_or_pkg::OPK_INCR_SKIP)
                        && result_zero_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cycle_end_reg <= 1'b0;
        end else begin
            cycle_end_reg <= (qphase_reg == 2'h3);
        end
    end

    assign qphase_o = qphase_reg;
    assign file_raddr_o = raddr_reg;
    assign file_wr_o = {fw_wr_en_reg, fw_addr_reg, fw_data_reg};
    assign working_register_o = w_reg;
    assign zero_flag_o = z_reg;
    assign skip_cycle_o = skip_reg;
    assign cycle_end_o = cycle_end_reg;

endmodule // incr_skip_and_or_ops

/* File: incr_skip_and_or_ops_props.sv */
`timescale 1ns/1ps
module incr_skip_and_or_ops_props (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [1:0] qphase_o,
    input wire logic [6:0] file_raddr_o,
    input wire incr_skip_or_pkg::file_write_t file_wr_o,
    input wire logic [7:0] working_register_o,
    input wire logic zero_flag_o,
    input wire logic skip_cycle_o,
    input wire logic cycle_end_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire run = qphase_o == 2'h3 && !skip_cycle_o;
    a_phase_step: assert property ($past(rst_n_i) |-> qphase_o == $past(qphase_o) + 2'h1)
        else $error("phase step");
    a_cycle_end: assert property (cycle_end_o == (qphase_o == 2'h0 && $past(qphase_o) == 2'h3))
        else $error("cycle end pulse");
    a_write_slot: assert property (file_wr_o.wr_en |-> run)
        else $error("write slot");
    a_skip_len: assert property ($rose(skip_cycle_o) |-> qphase_o == 2'h0
        ##1 skip_cycle_o [*3] ##1 !skip_cycle_o) else $error("skip length");
    a_skip_hold: assert property (skip_cycle_o |=> $stable(working_register_o)
        && $stable(zero_flag_o)) else $error("skip changed state");
    a_w_update: assert property (!$stable(working_register_o) |-> qphase_o == 2'h0)
        else $error("w update slot");
    a_lit_or: assert property (run && instr_i[13:8] == 6'h38 |=> working_register_o ==
        ($past(working_register_o) | $past(instr_i[7:0]))
        && zero_flag_o == (working_register_o == 8'h00)) else $error("literal or");
    a_incr_skip: assert property (run && instr_i[13:8] == 6'h0f |=> $stable(zero_flag_o)
        && skip_cycle_o == ($past(file_rdata_i, 3) == 8'hff)) else $error("incr skip");
    a_incr_wr: assert property (run && instr_i[13:8] == 6'h0f && instr_i[7] |->
        file_wr_o.wr_en && file_wr_o.addr == instr_i[6:0]
        && file_wr_o.data == $past(file_rdata_i, 2) + 8'h01) else $error("incr write");
    a_file_or: assert property (run && instr_i[13:8] == 6'h04 && !instr_i[7] |=>
        working_register_o == ($past(working_register_o) | $past(file_rdata_i, 3)))
        else $error("file or");
endmodule // incr_skip_and_or_ops_props
bind incr_skip_and_or_ops incr_skip_and_or_ops_props chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .instr_i(instr_i), .file_rdata_i(file_rdata_i), .qphase_o(qphase_o),
    .file_raddr_o(file_raddr_o), .file_wr_o(file_wr_o), .zero_flag_o(zero_flag_o),
    .working_register_o(working_register_o), .skip_cycle_o(skip_cycle_o),
    .cycle_end_o(cycle_end_o));

/* File: file_regs_model.sv */
`timescale 1ns/1ps
module file_regs_model (
    input wire logic mclk_i,
    input wire logic [6:0] file_raddr_i,
    input wire incr_skip_or_pkg::file_write_t file_wr_i,
    output logic [7:0] file_rdata_o
);
    logic [7:0] mem [128];
    // Reads are combinational, so data is settled long before the sampling edge.
    assign file_rdata_o = mem[file_raddr_i];
    always @(posedge mclk_i) begin
        if (file_wr_i.wr_en) begin
            mem[file_wr_i.addr] <= file_wr_i.data;
        end
    end
endmodule // file_regs_model

/* File: incr_skip_and_or_ops_tb.sv */
`timescale 1ns/1ps
module incr_skip_and_or_ops_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0] file_rdata_i;
    logic [1:0] qphase_o;
    logic [6:0] file_raddr_o;
    incr_skip_or_pkg::file_write_t file_wr_o;
    logic [7:0] working_register_o;
    logic zero_flag_o;
    logic skip_cycle_o;
    int miscompares = 0;
    int n_tests = 0;
    initial forever #5 mclk_i = ~mclk_i;
    incr_skip_and_or_ops uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .qphase_o(qphase_o), .file_raddr_o(file_raddr_o),
        .file_wr_o(file_wr_o), .working_register_o(working_register_o),
        .zero_flag_o(zero_flag_o), .skip_cycle_o(skip_cycle_o), .cycle_end_o());
    file_regs_model fm (.mclk_i(mclk_i), .file_raddr_i(file_raddr_o), .file_wr_i(file_wr_o),
        .file_rdata_o(file_rdata_i));
    task automatic print_verdict();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The word is held for the whole cycle; nxt is what stands in the following one.
    task automatic exec(input logic [13:0] word, input logic [13:0] nxt,
            input logic [7:0] w, input logic z, input logic skip);
        int n;
        n = 0;
        while (qphase_o !== 2'h3) begin
            @(negedge mclk_i);
            n++;
            if (n > 8) begin
                miscompares++;
                print_verdict();
            end
        end
        @(posedge mclk_i);
        instr_i <= word;
        repeat (4) @(posedge mclk_i);
        instr_i <= nxt;
        #1;
        cmp(working_register_o, w);
        cmp({6'h00, zero_flag_o, skip_cycle_o}, {6'h00, z, skip});
    endtask
    task automatic t_incr();
        exec(14'h3800, 14'h0000, 8'h00, 1'b1, 1'b0);
        exec(14'h0f10, 14'h0000, 8'h80, 1'b1, 1'b0);
        exec(14'h0f91, 14'h3801, 8'h80, 1'b1, 1'b1);
        cmp(fm.mem[17], 8'h00);
        exec(14'h3800, 14'h0000, 8'h80, 1'b0, 1'b0);
        $display("increment test done");
    endtask
    task automatic t_or_lit();
        exec(14'h389a, 14'h0000, 8'h9a, 1'b0, 1'b0);
        exec(14'h3835, 14'h0000, 8'hbf, 1'b0, 1'b0);
        $display("literal test done");
    endtask
    task automatic t_or_file();
        exec(14'h0485, 14'h0000, 8'hbf, 1'b0, 1'b0);
        cmp(fm.mem[5], 8'hff);
        exec(14'h0406, 14'h0000, 8'hff, 1'b0, 1'b0);
        $display("file test done");
    endtask
    initial begin
        fm.mem[5] = 8'h40;
        fm.mem[6] = 8'h40;
        fm.mem[16] = 8'h7f;
        fm.mem[17] = 8'hff;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_incr();
        t_or_lit();
        t_or_file();
        print_verdict();
    end
endmodule // incr_skip_and_or_ops_tb
